// file: hdl/arc_defines.svh
// Constants for the alarm relay output control block.
// Assumes a 200 MHz system clock and an AXI4-Lite register port.
//
// Operation
// - One indicator per relay, high while alarmed.
// - Delay zero to four seconds, 200 ms steps.
// - Polarity selects failsafe or energized-in-alarm drive.
// - Automatic release or latching per relay.
// - Per-relay push-button requests latched alarm exit.
// - Host clear acts like the push-button.
// - Clear needs normal input and elapsed delay.
// - Delay applies to entering and leaving alarm.
// - Host command resets registers, divider and relay channels.
// - Alarm status readable; polling can be toggled.
// - High limit trips rising, low trips falling.
// - Release only past setpoint by the deadband (minus for high limit, plus for low).
`ifndef ARC_DEFINES_SVH
`define ARC_DEFINES_SVH

`define ARC_CLK_MHZ        200
`define ARC_STEP_MS        200
`define ARC_STEP_CYCLES    (`ARC_STEP_MS * 1000 * `ARC_CLK_MHZ)
`define ARC_MAX_STEPS      5'h14

`define ARC_OFF_CTRL       4'h0
`define ARC_OFF_DELAY      4'h1
`define ARC_OFF_STATUS     4'h2
`define ARC_OFF_EVENT      4'h3
`define ARC_OFF_MASK       4'h4
`define ARC_OFF_CMD        4'h5

`define ARC_CTRL_RESET     8'h00
`define ARC_DELAY_RESET    5'h00
`define ARC_FLD_FAILSAFE   0
`define ARC_FLD_LATCH      1
`define ARC_FLD_HIGHLIM    2
`define ARC_FLD_POLL       8
`define ARC_CMD_CLEAR0     0
`define ARC_CMD_CLEAR1     1
`define ARC_CMD_MODRESET   8
`define ARC_RESP_OKAY      2'h0
`define ARC_RESP_SLVERR    2'h2

`endif

// file: hdl/arc_pkg.sv
// Types for the alarm relay output control block.
// Assumes arc_defines.svh is included by the design files.
package arc_pkg;
	typedef enum logic [1:0] {
		ARC_NORMAL  = 2'b00,
		ARC_ARMING  = 2'b01,
		ARC_ALARM   = 2'b10,
		ARC_LEAVING = 2'b11
	} arc_state_t;

	typedef struct packed {
		logic failsafe;
		logic latch;
		logic high_limit;
		logic [4:0] delay_steps;
	} arc_cfg_t;

	typedef struct packed {
		logic above_set;
		logic below_set;
		logic above_band;
		logic below_band;
	} arc_cmp_t;
endpackage

// file: hdl/arc_channel.sv
// One relay channel: delay qualification, latching and coil drive.
// Assumes compare flags and step tick come from the sys_clk domain.
`timescale 1ns/1ps
`include "arc_defines.svh"

module arc_channel (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// Configuration and stimulus
	input  wire arc_pkg::arc_cfg_t cfg,
	input  wire arc_pkg::arc_cmp_t cmp,
	input  wire logic             step_tick,
	input  wire logic             clear_req,
	// Outputs
	output logic                  in_alarm,
	output logic                  coil_on,
	output logic                  led_on,
	output logic                  enter_evt,
	output logic                  leave_evt
);
	import arc_pkg::*;

	arc_state_t state_reg;
	arc_state_t state_next;
	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;
	logic       led_reg;
	logic       coil_reg;

	wire trip_cond = cfg.high_limit ? cmp.above_set : cmp.below_set;
	wire norm_cond = cfg.high_limit ? cmp.below_band : cmp.above_band;
	wire expired   = (cnt_reg >= cfg.delay_steps);
	wire may_leave = norm_cond && (!cfg.latch || clear_req);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		enter_evt  = 1'b0;
		leave_evt  = 1'b0;
		case (state_reg)
		ARC_NORMAL: begin
			cnt_next = 5'h00;
			if (trip_cond)
				state_next = ARC_ARMING;
		end
		ARC_ARMING: begin
			if (!trip_cond) begin
				state_next = ARC_NORMAL;
				cnt_next   = 5'h00;
			end else if (expired) begin
				state_next = ARC_ALARM;
				cnt_next   = 5'h00;
				enter_evt  = 1'b1;
			end else if (step_tick) begin
				cnt_next = cnt_reg + 5'h01;
			end
		end
		ARC_ALARM: begin
			cnt_next = 5'h00;
			if (norm_cond)
				state_next = ARC_LEAVING;
		end
		ARC_LEAVING: begin
			if (!norm_cond) begin
				state_next = ARC_ALARM;
				cnt_next   = 5'h00;
			end else if (expired && may_leave) begin
				state_next = ARC_NORMAL;
				cnt_next   = 5'h00;
				leave_evt  = 1'b1;
			end else if (step_tick && !expired) begin
				cnt_next = cnt_reg + 5'h01;
			end
		end
		default: begin
			state_next = ARC_NORMAL;
			cnt_next   = 5'h00;
		end
		endcase
	end

	wire alarm_next = (state_next == ARC_ALARM) ||
		(state_next == ARC_LEAVING);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg <= ARC_NORMAL;
			cnt_reg   <= 5'h00;
			led_reg   <= 1'b0;
			coil_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			led_reg   <= alarm_next;
			coil_reg  <= alarm_next ^ cfg.failsafe;
		end
	end

	assign in_alarm = led_reg;
	assign led_on   = led_reg;
	assign coil_on  = coil_reg;

	led_tracks_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		led_on == (state_reg == ARC_ALARM || state_reg == ARC_LEAVING))
		else $error("led does not follow alarm state");
	coil_pol_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$stable(cfg.failsafe) |-> coil_on == (led_on ^ cfg.failsafe))
		else $error("coil polarity wrong");
	restart_cnt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ARC_ARMING && !trip_cond) |=> cnt_reg == 5'h00)
		else $error("counter not restarted");
	latch_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ARC_LEAVING && cfg.latch && !clear_req)
		|=> state_reg != ARC_NORMAL)
		else $error("latched alarm left without clear");
	enter_delay_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		enter_evt |-> cnt_reg >= cfg.delay_steps && trip_cond)
		else $error("alarm entered before delay");
	leave_norm_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		leave_evt |-> norm_cond && expired)
		else $error("alarm left before release met");
	trip_dir_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ARC_NORMAL && !trip_cond) |=> state_reg == ARC_NORMAL)
		else $error("armed without trip condition");
endmodule

// file: hdl/arc_top.sv
// Two-relay alarm output control with AXI4-Lite registers.
// Assumes compare flags are synchronous; buttons are raw pins.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "arc_defines.svh"

module arc_top #(
	parameter int STEP_CYCLES = `ARC_STEP_CYCLES
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// AXI4-Lite write
	input  wire logic [5:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [5:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Comparison stage
	input  wire arc_pkg::arc_cmp_t cmp_one,
	input  wire arc_pkg::arc_cmp_t cmp_two,
	// Front panel
	input  wire logic              relay_one_clear_button,
	input  wire logic              relay_two_clear_button,
	// Relay drive and indicators
	output logic [1:0]             coil_on,
	output logic [1:0]             led_on,
	output logic                   irq
);
	import arc_pkg::*;

	// ****************************************************
	// Module reset and step divider
	// ****************************************************
	logic        mod_reset_reg;
	wire         core_rst_n = rst_n && !mod_reset_reg;
	logic [31:0] div_reg;
	wire         step_tick = (div_reg == STEP_CYCLES - 1);

	always_ff @(posedge sys_clk) begin
		if (!core_rst_n || step_tick)
			div_reg <= 32'h0;
		else
			div_reg <= div_reg + 32'h1;
	end

	// ****************************************************
	// Button synchronisers and press detect
	// ****************************************************
	logic [1:0] btn_s1_reg;
	logic [1:0] btn_s2_reg;
	logic [1:0] btn_s3_reg;
	wire  [1:0] btn_raw = {relay_two_clear_button, relay_one_clear_button};
	wire  [1:0] btn_press = btn_s2_reg & ~btn_s3_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			btn_s1_reg <= 2'h0;
			btn_s2_reg <= 2'h0;
			btn_s3_reg <= 2'h0;
		end else begin
			btn_s1_reg <= btn_raw;
			btn_s2_reg <= btn_s1_reg;
			btn_s3_reg <= btn_s2_reg;
		end
	end

	// ****************************************************
	// Registers
	// ****************************************************
	logic [7:0]  ctrl_reg;
	logic [9:0]  delay_reg;
	logic [1:0]  event_reg;
	logic [1:0]  mask_reg;
	logic        poll_reg;
	logic [1:0]  host_clr_reg;
	logic [1:0]  alarm;
	logic [1:0]  enter_evt;
	logic [1:0]  leave_evt;

	logic        aw_held_reg;
	logic [3:0]  aw_idx_reg;
	logic        w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;

	wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	wire wr_ctrl  = do_write && aw_idx_reg == `ARC_OFF_CTRL && w_strb_reg[0];
	wire wr_delay = do_write && aw_idx_reg == `ARC_OFF_DELAY;
	wire wr_event = do_write && aw_idx_reg == `ARC_OFF_EVENT && w_strb_reg[0];
	wire wr_mask  = do_write && aw_idx_reg == `ARC_OFF_MASK && w_strb_reg[0];
	wire wr_cmd   = do_write && aw_idx_reg == `ARC_OFF_CMD;
	wire wr_known = aw_idx_reg <= `ARC_OFF_CMD;
	wire [1:0] evt_set = enter_evt | leave_evt;
	wire [1:0] clear_req = btn_press | host_clr_reg;

	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready  = !w_held_reg;
	assign s_axi_arready = !rvalid_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			aw_held_reg <= 1'b0;
			aw_idx_reg  <= 4'h0;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 32'h0;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `ARC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_held_reg) begin
				aw_held_reg <= 1'b1;
				aw_idx_reg  <= s_axi_awaddr[5:2];
			end
			if (s_axi_wvalid && !w_held_reg) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_known ? `ARC_RESP_OKAY : `ARC_RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!core_rst_n) begin
			ctrl_reg     <= `ARC_CTRL_RESET;
			delay_reg    <= {`ARC_DELAY_RESET, `ARC_DELAY_RESET};
			event_reg    <= 2'h0;
			mask_reg     <= 2'h0;
			poll_reg     <= 1'b0;
			host_clr_reg <= 2'h0;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= w_data_reg[7:0];
			if (do_write && aw_idx_reg == `ARC_OFF_CTRL && w_strb_reg[1])
				poll_reg <= w_data_reg[`ARC_FLD_POLL];
			if (wr_delay && w_strb_reg[0])
				delay_reg[4:0] <= clamp(w_data_reg[4:0]);
			if (wr_delay && w_strb_reg[1])
				delay_reg[9:5] <= clamp(w_data_reg[12:8]);
			if (wr_mask)
				mask_reg <= w_data_reg[1:0];
			event_reg <= (event_reg & ~(wr_event ? w_data_reg[1:0] : 2'h0))
				| evt_set;
			host_clr_reg <= (wr_cmd && w_strb_reg[0]) ?
				w_data_reg[`ARC_CMD_CLEAR1:`ARC_CMD_CLEAR0] : 2'h0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			mod_reset_reg <= 1'b0;
		else
			mod_reset_reg <= wr_cmd && w_strb_reg[1] &&
				w_data_reg[`ARC_CMD_MODRESET];
	end

	function automatic logic [4:0] clamp(input logic [4:0] v);
		clamp = (v > `ARC_MAX_STEPS) ? `ARC_MAX_STEPS : v;
	endfunction

	// ****************************************************
	// Read channel
	// ****************************************************
	wire [3:0]  ar_idx = s_axi_araddr[5:2];
	wire [31:0] stat_word = poll_reg ? {30'h0, alarm} : 32'h0;
	wire [31:0] rd_mux =
		(ar_idx == `ARC_OFF_CTRL)   ? {23'h0, poll_reg, ctrl_reg} :
		(ar_idx == `ARC_OFF_DELAY)  ? {19'h0, delay_reg[9:5],
			3'h0, delay_reg[4:0]} :
		(ar_idx == `ARC_OFF_STATUS) ? stat_word :
		(ar_idx == `ARC_OFF_EVENT)  ? {30'h0, event_reg} :
		(ar_idx == `ARC_OFF_MASK)   ? {30'h0, mask_reg} : 32'h0;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0;
			rresp_reg  <= `ARC_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_mux;
			rresp_reg  <= (ar_idx <= `ARC_OFF_CMD) ?
				`ARC_RESP_OKAY : `ARC_RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;
	assign irq          = |(event_reg & mask_reg);

	// ****************************************************
	// Relay channels
	// ****************************************************
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			wire arc_cfg_t cfg = '{
				failsafe:    ctrl_reg[4*g + `ARC_FLD_FAILSAFE],
				latch:       ctrl_reg[4*g + `ARC_FLD_LATCH],
				high_limit:  ctrl_reg[4*g + `ARC_FLD_HIGHLIM],
				delay_steps: delay_reg[5*g +: 5]
			};
			wire arc_cmp_t cmp_ch = (g == 0) ? cmp_one : cmp_two;
			arc_channel u_ch (
				.sys_clk   (sys_clk),
				.rst_n     (core_rst_n),
				.cfg       (cfg),
				.cmp       (cmp_ch),
				.step_tick (step_tick),
				.clear_req (clear_req[g]),
				.in_alarm  (alarm[g]),
				.coil_on   (coil_on[g]),
				.led_on    (led_on[g]),
				.enter_evt (enter_evt[g]),
				.leave_evt (leave_evt[g])
			);
		end
	endgenerate

	evt_sticky_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
		evt_set[0] |=> event_reg[0])
		else $error("event lost against clear");
	irq_level_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
		(irq && !wr_event && !wr_mask) |=> irq)
		else $error("irq dropped without clear");
	mod_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mod_reset_reg |=> led_on == 2'b00 && ctrl_reg == `ARC_CTRL_RESET)
		else $error("module reset ineffective");
	poll_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_axi_arvalid && !rvalid_reg && ar_idx == `ARC_OFF_STATUS &&
			!poll_reg) |=> rdata_reg == 32'h0)
		else $error("status read while polling off");
	host_clear_a: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
		(wr_cmd && w_strb_reg[0] && w_data_reg[0]) |=> clear_req[0])
		else $error("host clear not delivered");
endmodule

// file: tb/arc_cmp_model.sv
// Stand-in for the comparison stage: level in, limit flags out.
// Assumes the level changes only just after a sys_clk edge.
`timescale 1ns/1ps

module arc_cmp_model #(
	parameter int SETPOINT = 100,
	parameter int DEADBAND = 10
) (
	// Measured input
	input  wire logic [15:0]  level,
	// Flags to the relay logic
	output arc_pkg::arc_cmp_t cmp
);
	import arc_pkg::*;

	assign cmp.above_set  = level > SETPOINT;
	assign cmp.below_set  = level < SETPOINT;
	assign cmp.above_band = level > SETPOINT + DEADBAND;
	assign cmp.below_band = level < SETPOINT - DEADBAND;
endmodule

// file: tb/arc_top_tb.sv
// Self-checking bench for arc_top over its AXI4-Lite port.
// Assumes STEP_CYCLES of 4 and the comparison stand-in model.
`timescale 1ns/1ps
`include "arc_defines.svh"

module arc_top_tb;
	import arc_pkg::*;

	logic              sys_clk = 1'b0;
	logic              rst_n;
	logic [5:0]        s_axi_awaddr, s_axi_araddr;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic              s_axi_arvalid, s_axi_arready;
	logic              s_axi_rvalid, s_axi_rready;
	logic [31:0]       s_axi_wdata, s_axi_rdata;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp, coil_on, led_on;
	arc_cmp_t          cmp_one, cmp_two;
	logic              relay_one_clear_button, relay_two_clear_button;
	logic              irq;
	logic [15:0]       lvl [2];
	int                failures = 0;
	int                n_tests = 0;

	always #2.5 sys_clk = ~sys_clk;

	arc_cmp_model arc_cmp_model_i0 (.level(lvl[0]), .cmp(cmp_one));
	arc_cmp_model arc_cmp_model_i1 (.level(lvl[1]), .cmp(cmp_two));
	arc_top #(.STEP_CYCLES(4)) arc_top_i (.sys_clk, .rst_n, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.cmp_one, .cmp_two, .relay_one_clear_button,
		.relay_two_clear_button, .coil_on, .led_on, .irq);

	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic complete_run();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			failures++;
		end
	endtask

	task automatic timed_out();
		$display("ERROR wait expected answer seen timeout");
		failures++;
		complete_run();
	endtask

	task automatic wr(logic [5:0] a, logic [31:0] d, logic [1:0] er);
		int n;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				chk("bresp", er, s_axi_bresp);
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (n == 40)
			timed_out();
	endtask

	task automatic rd(logic [5:0] a, logic [31:0] ed, logic [1:0] er);
		int n;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				chk("rdata", ed, s_axi_rdata);
				chk("rresp", er, s_axi_rresp);
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (n == 40)
			timed_out();
	endtask

	task automatic set_lvl(int ch, logic [15:0] v);
		@(posedge sys_clk);
		lvl[ch] <= v;
	endtask

	task automatic steady(int ch, logic v, int cycles);
		logic bad;
		bad = 1'b0;
		repeat (cycles) begin
			@(negedge sys_clk);
			if (led_on[ch] !== v)
				bad = 1'b1;
		end
		chk("led held", 0, bad);
	endtask

	task automatic wait_led(int ch, logic v);
		int n;
		for (n = 0; n < 40; n++) begin
			@(negedge sys_clk);
			if (led_on[ch] === v)
				break;
		end
		if (n == 40)
			timed_out();
		else
			chk("led", v, led_on[ch]);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	localparam logic [5:0] A_CTRL = {`ARC_OFF_CTRL, 2'b00};
	localparam logic [5:0] A_DLY = {`ARC_OFF_DELAY, 2'b00};
	localparam logic [5:0] A_STAT = {`ARC_OFF_STATUS, 2'b00};
	localparam logic [5:0] A_EVT = {`ARC_OFF_EVENT, 2'b00};
	localparam logic [5:0] A_MASK = {`ARC_OFF_MASK, 2'b00};
	localparam logic [5:0] A_CMD = {`ARC_OFF_CMD, 2'b00};
	localparam logic [1:0] OK = `ARC_RESP_OKAY;
	localparam logic [1:0] ERR = `ARC_RESP_SLVERR;

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready} = 2'b00;
		s_axi_awaddr = 6'h00;
		s_axi_araddr = 6'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		relay_one_clear_button = 1'b0;
		relay_two_clear_button = 1'b0;
		lvl[0] = 16'h0064;
		lvl[1] = 16'h0096;
		rst_n = 1'b0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(A_CTRL, 32'h0, OK);
		chk("coil", 2'b00, coil_on);
		rd(6'h18, 32'h0, ERR);
		wr(6'h18, 32'h0, ERR);
		wr(A_DLY, 32'h1f1f, OK);
		rd(A_DLY, 32'h1414, OK);
		wr(A_DLY, 32'h0102, OK);
		wr(A_CTRL, 32'h134, OK);
		wr(A_MASK, 32'hffffffff, OK);
		repeat (3) @(negedge sys_clk);
		chk("coil", 2'b10, coil_on);
		$display("registers done");
		set_lvl(0, 16'h0078);
		set_lvl(0, 16'h0032);
		steady(0, 1'b0, 20);
		set_lvl(0, 16'h0078);
		steady(0, 1'b0, 3);
		wait_led(0, 1'b1);
		chk("coil", 2'b11, coil_on);
		rd(A_STAT, 32'h1, OK);
		wr(A_CTRL, 32'h034, OK);
		rd(A_STAT, 32'h0, OK);
		wr(A_CTRL, 32'h134, OK);
		set_lvl(0, 16'h005f);
		steady(0, 1'b1, 20);
		set_lvl(0, 16'h0032);
		steady(0, 1'b1, 3);
		wait_led(0, 1'b0);
		$display("auto release done");
		wr(A_MASK, 32'h0, OK);
		chk("irq masked", 0, irq);
		wr(A_MASK, 32'hffffffff, OK);
		chk("irq", 1, irq);
		wr(A_EVT, 32'hffffffff, OK);
		rd(A_EVT, 32'h0, OK);
		chk("irq cleared", 0, irq);
		$display("interrupt done");
		set_lvl(1, 16'h0050);
		wait_led(1, 1'b1);
		chk("coil", 2'b00, coil_on);
		wr(A_CMD, 32'h3, OK);
		set_lvl(1, 16'h0096);
		steady(1, 1'b1, 20);
		@(posedge sys_clk);
		relay_two_clear_button <= 1'b1;
		repeat (4) @(posedge sys_clk);
		relay_two_clear_button <= 1'b0;
		wait_led(1, 1'b0);
		set_lvl(1, 16'h0050);
		wait_led(1, 1'b1);
		set_lvl(1, 16'h0096);
		steady(1, 1'b1, 12);
		wr(A_CMD, 32'h2, OK);
		wait_led(1, 1'b0);
		$display("latch done");
		set_lvl(0, 16'h0064);
		set_lvl(1, 16'h0064);
		wr(A_CMD, 32'h100, OK);
		rd(A_CTRL, 32'h0, OK);
		rd(A_DLY, 32'h0, OK);
		chk("coil", 2'b00, coil_on);
		$display("module reset done");
		complete_run();
	end
endmodule
